/* hw/pwm_channel_ctl.sv */
/*
  PWM channel control: per-channel enable with clock-source synchronisation,
  start polarity, plain/scaled clock selection and 16-bit pair joining,
  reached over a classic Wishbone slave (32-bit, word per register).
  Assumes the prescaler, scalers and channel counters sit outside on the
  same clock and hand over clock enables, period-start and duty-match
  pulses as one-cycle strobes in the MCLK_I domain.
*/
// The Wishbone register port was chosen for this implementation.
// Function
// - A set enable drives the pin at once, the waveform from the next source clock tick.
// - Enable register bit n belongs to channel n for n from 0 to 7.
// - The first period after enabling may be irregular and is not corrected.
// - A joined pair is enabled only by its odd channel bit; the even pin is held off.
// - In run mode, all enables low stops the shared prescaler.
// - Polarity one: pin high at period start, low at the duty count.
// - Polarity zero: pin low at period start, high at the duty count.
// - Polarity accepts writes at any time, and a change acts at once.
// - Channels 0, 1, 4 and 5 take clock A on select 0 and scaled clock A on 1.
// - Channels 2, 3, 6 and 7 take clock B on select 0 and scaled clock B on 1.
// - Clock select accepts writes at any time and switches at once.
// - Enable, polarity and clock select are read and written with no restriction.
// - A joined pair forms one 16-bit channel whose waveform leaves on the odd pin.
// - Clocks A and B are the plain sources of their channel groups.
`timescale 1ns/100ps
`default_nettype none

module pwm_channel_ctl
(
  input  wire logic        MCLK_I,
  input  wire logic        SRST_I,
  // classic Wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [4:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  // clock sources, one-cycle enables
  input  wire logic        CLOCK_A_I,
  input  wire logic        CLOCK_B_I,
  input  wire logic        SCALED_CLOCK_A_I,
  input  wire logic        SCALED_CLOCK_B_I,
  input  wire logic        RUN_MODE_I,
  // per-channel counter events, one-cycle pulses
  input  wire logic [7:0]  PERIOD_START_I,
  input  wire logic [7:0]  DUTY_MATCH_I,
  // to counters and pins
  output logic [7:0]       CHANNEL_CLOCK_O,
  output logic             PRESCALE_RUN_O,
  output logic [7:0]       PWM_O,
  output logic [7:0]       PWM_OE_O
);

  typedef struct packed {
    logic [7:0]  channel_enable;
    logic [7:0]  channel_polarity;
    logic [7:0]  channel_clock_select;
    logic [3:0]  join_pair;
    logic [7:0]  running;
    logic [7:0]  before_duty;
    logic [7:0]  pin;
    logic [7:0]  pin_oe;
    logic [7:0]  chan_clock;
    logic        prescale_run;
    logic        ack;
    logic [31:0] rdata;
  } state_t;

  state_t q;
  state_t next_q;

  logic [7:0] live_enable;
  logic [7:0] src_clock;
  logic       access;
  logic       wr_lane0;
  logic [2:0] idx;

  assign access   = CYC_I && STB_I && !q.ack;
  assign wr_lane0 = access && WE_I && SEL_I[0];
  assign idx      = ADR_I[pwm_ctl_pkg::IDX_LSB +: pwm_ctl_pkg::IDX_W];

  genvar g;
  generate
    for (g = 0; g < pwm_ctl_pkg::CHANNELS; g++)
    begin : g_chan
      localparam bit GROUP_A = ((g / 2) % 2) == 0;
      localparam bit ODD     = (g % 2) == 1;
      logic base_clk;
      logic scaled_clk;
      assign base_clk   = GROUP_A ? CLOCK_A_I : CLOCK_B_I;
      assign scaled_clk = GROUP_A ? SCALED_CLOCK_A_I : SCALED_CLOCK_B_I;
      assign src_clock[g] =
        (q.channel_clock_select[g] == pwm_ctl_pkg::CLKSEL_SCALED) ?
        scaled_clk : base_clk;
      // joined even channel ignores its bit
      if (ODD)
      begin : g_odd
        assign live_enable[g] = q.channel_enable[g];
      end
      else
      begin : g_even
        assign live_enable[g] = q.channel_enable[g] && !q.join_pair[g / 2];
      end
    end
  endgenerate

  always_comb
  begin
    next_q = q;

    // bus: ack answers one cycle after the strobe, then drops
    next_q.ack = access;
    if (access && !WE_I)
    begin
      unique case (idx)
        pwm_ctl_pkg::IDX_CHANNEL_ENABLE:
          next_q.rdata = {24'h000000, q.channel_enable};
        pwm_ctl_pkg::IDX_CHANNEL_POLARITY:
          next_q.rdata = {24'h000000, q.channel_polarity};
        pwm_ctl_pkg::IDX_CHANNEL_CLOCK_SELECT:
          next_q.rdata = {24'h000000, q.channel_clock_select};
        pwm_ctl_pkg::IDX_CHANNEL_JOIN:
          next_q.rdata = {24'h000000, q.join_pair, 4'h0};
        pwm_ctl_pkg::IDX_CHANNEL_STATUS:
          next_q.rdata = {24'h000000, q.running};
        default:
          next_q.rdata = 32'h00000000;
      endcase
    end

    if (wr_lane0)
    begin
      // writes at any time, no channel-state lockout
      unique case (idx)
        pwm_ctl_pkg::IDX_CHANNEL_ENABLE:
          next_q.channel_enable = DAT_I[7:0];
        pwm_ctl_pkg::IDX_CHANNEL_POLARITY:
          next_q.channel_polarity = DAT_I[7:0];
        pwm_ctl_pkg::IDX_CHANNEL_CLOCK_SELECT:
          next_q.channel_clock_select = DAT_I[7:0];
        pwm_ctl_pkg::IDX_CHANNEL_JOIN:
          next_q.join_pair = DAT_I[pwm_ctl_pkg::JOIN_LSB +: pwm_ctl_pkg::PAIRS];
        default:
          next_q.rdata = q.rdata;
      endcase
    end

    // prescaler stops when every enable bit is low, the even bit of a joined pair included
    next_q.prescale_run = RUN_MODE_I && (q.channel_enable != 8'h00);

    for (int i = 0; i < pwm_ctl_pkg::CHANNELS; i++)
    begin
      next_q.chan_clock[i] = src_clock[i] && live_enable[i];
      next_q.pin_oe[i] = live_enable[i];
      if (!live_enable[i])
      begin
        next_q.running[i]     = 1'b0;
        next_q.before_duty[i] = 1'b1;
      end
      // waveform waits for the source tick
      else if (!q.running[i] && src_clock[i])
      begin
        next_q.running[i]     = 1'b1;
        next_q.before_duty[i] = 1'b1;
      end
      // no fix-up of a partial first period
      else if (q.running[i])
      begin
        if (PERIOD_START_I[i])
          next_q.before_duty[i] = 1'b1;
        else if (DUTY_MATCH_I[i])
          next_q.before_duty[i] = 1'b0;
      end

      // new polarity shows at once, so a pulse may be cut short
      if (!live_enable[i])
        next_q.pin[i] = 1'b0;
      else if (next_q.before_duty[i])
        next_q.pin[i] = q.channel_polarity[i];
      else
        next_q.pin[i] = !q.channel_polarity[i];
    end
    // even pin of a joined pair carries nothing
    for (int k = 0; k < pwm_ctl_pkg::PAIRS; k++)
    begin
      if (q.join_pair[k])
      begin
        next_q.pin[2 * k]    = 1'b0;
        next_q.pin_oe[2 * k] = 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (SRST_I)
    begin
      q                      <= '0;
      q.channel_enable       <= pwm_ctl_pkg::ENABLE_RESET;
      q.channel_polarity     <= pwm_ctl_pkg::POLARITY_RESET;
      q.channel_clock_select <= pwm_ctl_pkg::CLKSEL_RESET;
      q.join_pair            <= pwm_ctl_pkg::JOIN_RESET;
      q.before_duty          <= 8'hFF;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign DAT_O           = q.rdata;
  assign ACK_O           = q.ack;
  assign CHANNEL_CLOCK_O = q.chan_clock;
  assign PRESCALE_RUN_O  = q.prescale_run;
  assign PWM_O           = q.pin;
  assign PWM_OE_O        = q.pin_oe;

endmodule // pwm_channel_ctl

`default_nettype wire

/* shared/pwm_ctl_pkg.sv */
/*
  Package for the PWM channel enable / polarity / clock select block:
  register indices, field positions, reset values and bus widths.
  Assumes a 32-bit classic Wishbone slave with word-aligned registers.
*/
`default_nettype none

package pwm_ctl_pkg;

  localparam int unsigned CHANNELS   = 8;
  localparam int unsigned PAIRS      = 4;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ADDR_W     = 5;
  localparam int unsigned IDX_W      = 3;
  localparam int unsigned IDX_LSB    = 2;

  // register indices; byte address is four times the index
  localparam logic [2:0] IDX_CHANNEL_ENABLE       = 3'h0;
  localparam logic [2:0] IDX_CHANNEL_POLARITY     = 3'h1;
  localparam logic [2:0] IDX_CHANNEL_CLOCK_SELECT = 3'h2;
  localparam logic [2:0] IDX_CHANNEL_JOIN         = 3'h5;
  localparam logic [2:0] IDX_CHANNEL_STATUS       = 3'h6;

  // join register: pair k is joined by bit JOIN_LSB + k
  localparam int unsigned JOIN_LSB   = 4;

  localparam logic [7:0] ENABLE_RESET   = 8'h00;
  localparam logic [7:0] POLARITY_RESET = 8'h00;
  localparam logic [7:0] CLKSEL_RESET   = 8'h00;
  localparam logic [3:0] JOIN_RESET     = 4'h0;

  // clock select bit values
  localparam logic CLKSEL_PLAIN  = 1'b0;
  localparam logic CLKSEL_SCALED = 1'b1;

endpackage : pwm_ctl_pkg

`default_nettype wire

/* tb/pwm_ctl_monitor.sv */
/* port checker for pwm_channel_ctl
   assumes every port lives on MCLK_I with SRST_I as reset */
`timescale 1ns/100ps
`default_nettype none
module pwm_ctl_monitor
(
  input wire logic       MCLK_I,
  input wire logic       SRST_I,
  input wire logic       CYC_I,
  input wire logic       STB_I,
  input wire logic       RUN_MODE_I,
  input wire logic       CLOCK_A_I,
  input wire logic       CLOCK_B_I,
  input wire logic       SCALED_CLOCK_A_I,
  input wire logic       SCALED_CLOCK_B_I,
  input wire logic       ACK_O,
  input wire logic       PRESCALE_RUN_O,
  input wire logic [7:0] CHANNEL_CLOCK_O,
  input wire logic [7:0] PWM_O,
  input wire logic [7:0] PWM_OE_O,
  input wire logic [7:0] DUTY_MATCH_I,
  input wire logic [7:0] PERIOD_START_I
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  wire logic [3:0] grp_a = {CHANNEL_CLOCK_O[5:4], CHANNEL_CLOCK_O[1:0]};
  wire logic [3:0] grp_b = {CHANNEL_CLOCK_O[7:6], CHANNEL_CLOCK_O[3:2]};
  a_ack_answers: assert property
    (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("bus request not acked");
  a_ack_single: assert property (ACK_O |=> !ACK_O)
    else $error("ack held too long");
  a_prescale_stop: assert property
    (!RUN_MODE_I |=> !PRESCALE_RUN_O)
    else $error("prescaler runs outside run mode");
  a_pin_undriven: assert property
    ((PWM_O & ~PWM_OE_O) == 8'h00)
    else $error("undriven pin not low");
  a_group_a: assert property
    (|grp_a |-> $past(CLOCK_A_I | SCALED_CLOCK_A_I))
    else $error("group a tick without source");
  a_group_b: assert property
    (|grp_b |-> $past(CLOCK_B_I | SCALED_CLOCK_B_I))
    else $error("group b tick without source");
  a_oe_cause: assert property
    ($changed(PWM_OE_O) |-> $past(ACK_O))
    else $error("pin enable moved without write");
  // pins move only after a register write or a counter event
  a_pin_cause: assert property
    ($changed(PWM_O) |-> $past(ACK_O || |DUTY_MATCH_I || |PERIOD_START_I))
    else $error("pin moved without cause");
  c_join: cover property (PWM_OE_O == 8'hAA);
  c_scaled: cover property (SCALED_CLOCK_A_I ##1 |grp_a);
  c_duty: cover property (|DUTY_MATCH_I ##1 $changed(PWM_O));
endmodule // pwm_ctl_monitor
bind pwm_channel_ctl pwm_ctl_monitor i_pwm_ctl_monitor (.*);
`default_nettype wire

/* tb/tb_pwm_channel_ctl.sv */
/* bench for pwm_channel_ctl: registers, enables, routing, polarity, joining
   assumes the bench alone drives every port of the block */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a,b) begin n_tests++; if ((a)!==(b)) begin failures++; \
$display("mismatch %0t value %h", $time, a); end end
module tb_pwm_channel_ctl;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ra = 0, ack, prun;
  logic [3:0]  sel = 4'h0, src = 4'h0;
  logic [4:0]  adr = 5'h00;
  logic [7:0]  dm = 8'h00, ps = 8'h00, cc, pin, oe, c, p;
  logic [31:0] wd = 32'h0, rdat, q;
  int          failures = 0, n_tests = 0;
  pwm_channel_ctl i_pwm_channel_ctl (.MCLK_I(clk), .SRST_I(rst),
    .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
    .DAT_I(wd), .DAT_O(rdat), .ACK_O(ack), .CLOCK_A_I(src[0]),
    .CLOCK_B_I(src[1]), .SCALED_CLOCK_A_I(src[2]),
    .SCALED_CLOCK_B_I(src[3]), .RUN_MODE_I(ra), .PERIOD_START_I(ps),
    .DUTY_MATCH_I(dm), .CHANNEL_CLOCK_O(cc), .PRESCALE_RUN_O(prun),
    .PWM_O(pin), .PWM_OE_O(oe));
  initial forever #50 clk = ~clk;
  task automatic acc(input logic w, input logic [4:0] a,
                     input logic [7:0] d, input logic [3:0] s = 4'hF);
    {cyc, stb, we, adr, sel, wd} <= {2'b11, w, a, s, 24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    acc(1'b0, a, 8'h00);
    `CHK(q, e)
  endtask
  // one-cycle source and counter strobes, outputs caught mid-cycle
  task automatic tick(input logic [3:0] s, input logic [7:0] d, e);
    {src, dm, ps} <= {s, d, e};
    @(posedge clk);
    {src, dm, ps} <= 20'h0;
    @(negedge clk);
    {c, p} = {cc, pin};
    @(posedge clk);
  endtask
  task automatic t_regs;
    rdc(5'h00, 32'h0);
    rdc(5'h04, 32'h0);
    acc(1'b1, 5'h04, 8'hA5);
    acc(1'b1, 5'h08, 8'h3C);
    acc(1'b1, 5'h04, 8'hFF, 4'h0);
    acc(1'b1, 5'h1C, 8'h77);
    rdc(5'h04, 32'hA5);
    rdc(5'h08, 32'h3C);
    rdc(5'h1C, 32'h0);
    $display("done regs");
  endtask
  task automatic t_en;
    ra <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      acc(1'b1, 5'h00, 8'h01 << i);
      `CHK(oe, 8'h01 << i)
      `CHK(pin, 8'hA5 & (8'h01 << i))
    end
    `CHK(prun, 1'b1)
    acc(1'b1, 5'h00, 8'h00);
    `CHK(prun, 1'b0)
    $display("done enable");
  endtask
  task automatic t_route;
    logic [7:0] e[8] = '{8'h33, 8'hCC, 8'h00, 8'h00,
                         8'h00, 8'h00, 8'h33, 8'hCC};
    acc(1'b1, 5'h00, 8'hFF);
    for (int i = 0; i < 8; i++)
    begin
      if (i % 4 == 0) acc(1'b1, 5'h08, i < 4 ? 8'h00 : 8'hFF);
      tick(4'h1 << (i % 4), 8'h00, 8'h00);
      `CHK(c, e[i])
    end
    $display("done route");
  endtask
  task automatic t_pol;
    rdc(5'h18, 32'hFF);
    acc(1'b1, 5'h08, 8'h00);
    acc(1'b1, 5'h04, 8'h0F);
    `CHK(pin, 8'h0F)
    tick(4'h3, 8'h00, 8'h00);
    tick(4'h0, 8'hFF, 8'h00);
    `CHK(p, 8'hF0)
    tick(4'h0, 8'h00, 8'hFF);
    `CHK(p, 8'h0F)
    acc(1'b1, 5'h04, 8'hF0);
    `CHK(pin, 8'hF0)
    tick(4'h0, 8'hFF, 8'h0F);
    `CHK(p, 8'h00)
    $display("done polarity");
  endtask
  task automatic t_join;
    acc(1'b1, 5'h14, 8'hF0);
    `CHK(oe, 8'hAA)
    rdc(5'h14, 32'hF0);
    acc(1'b1, 5'h00, 8'h55);
    `CHK(oe, 8'h00)
    acc(1'b1, 5'h00, 8'hAA);
    `CHK(pin, 8'hA0)
    acc(1'b1, 5'h14, 8'h00);
    `CHK(oe, 8'hAA)
    $display("done join");
  endtask
  task automatic final_report;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_en();
    t_route();
    t_pol();
    t_join();
    final_report();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    failures++;
    final_report();
  end
endmodule // tb_pwm_channel_ctl
`default_nettype wire
